//--- core/crd_pkg.sv
// package of constants and types for the reset distribution block
package crd_pkg;
    localparam int unsigned CRD_CLK_MHZ          = 250;
    localparam int unsigned CRD_RATIO_HOLD_CLKS  = 2;
    localparam int unsigned CRD_BREQ_HOLD_CLKS   = 2;
    localparam int unsigned CRD_CFG_TAIL_CLKS    = 1;
    localparam int unsigned CRD_REFRESH_PER_BANK = 8;
    localparam int unsigned CRD_BANKS            = 4;
    localparam int unsigned CRD_RESET_CLKS       = 16;
    localparam int unsigned CRD_CFG_W            = 13;
    localparam logic [12:0] CRD_CFG_RESET        = 13'h0000;
    localparam int unsigned CRD_BRIDGES          = 2;
    localparam int unsigned CRD_REPHASE_CLKS     = 4;
    localparam logic        CRD_REPHASE_RESET    = 1'b1;
    localparam int unsigned CRD_CNT_W            = 8;
    typedef enum logic [1:0] {CRD_NONE, CRD_HARD, CRD_SOFT, CRD_BRIDGE} crd_cmd_t;
    typedef enum {CRD_ST_IDLE, CRD_ST_RESET, CRD_ST_TAIL, CRD_ST_REFRESH} crd_state_t;
endpackage : crd_pkg

//--- core/crd_link_if.sv
// interface carrying reset distribution signals between controller and far side
`timescale 1ns/100ps
`default_nettype none
interface crd_link_if;
    import crd_pkg::*;
    logic                 power_good_buffered_out;
    logic                 cpu_reset_n;
    logic                 ratio_hold_reset_n;
    logic                 memory_subsystem_reset_n;
    logic [CRD_BRIDGES-1:0] bridge_reset_n;
    logic                 cpu_init_o;
    logic                 cpu_init_oe;
    logic [CRD_CFG_W-1:0] addr_o;
    logic                 addr_oe;
    logic [CRD_CFG_W-1:0] addr_i;
    logic                 bus_request_zero_o;
    logic                 bus_request_zero_oe;
    logic                 refresh_strobe;
    logic [1:0]           refresh_bank;
    logic                 rephase;
    modport ctrl (output power_good_buffered_out, cpu_reset_n, ratio_hold_reset_n, memory_subsystem_reset_n,
                  bridge_reset_n, cpu_init_o, cpu_init_oe, addr_o, addr_oe, bus_request_zero_o,
                  bus_request_zero_oe, refresh_strobe, refresh_bank, rephase, input addr_i);
    modport far (input power_good_buffered_out, cpu_reset_n, ratio_hold_reset_n, memory_subsystem_reset_n,
                 bridge_reset_n, cpu_init_o, cpu_init_oe, addr_o, addr_oe, bus_request_zero_o,
                 bus_request_zero_oe, refresh_strobe, refresh_bank, rephase, output addr_i);
endinterface : crd_link_if
`default_nettype wire

//--- core/crd_ctrl.sv
// memory and i/o controller end: reset sequencing with wishbone register port
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module crd_ctrl
    import crd_pkg::*;
#(
    parameter int unsigned RESET_CLKS = CRD_RESET_CLKS,
    parameter int unsigned BANKS      = CRD_BANKS
) (
    input  wire logic        CLK,          // host clock
    input  wire logic        RST_N,        // synchronous reset, doubles as power-good
    input  wire logic        CYC_I,        // wishbone cycle
    input  wire logic        STB_I,        // wishbone strobe
    input  wire logic        WE_I,         // wishbone write
    input  wire logic [3:0]  ADR_I,        // wishbone byte address
    input  wire logic [3:0]  SEL_I,        // wishbone byte selects
    input  wire logic [31:0] DAT_I,        // wishbone write data
    output logic      [31:0] DAT_O,        // wishbone read data
    output logic             ACK_O,        // wishbone acknowledge
    crd_link_if.ctrl         LINK          // link to far side
);
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_CFG    = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_CAPT   = 4'hC;
    localparam int unsigned TAIL_CLKS = CRD_RATIO_HOLD_CLKS > CRD_BREQ_HOLD_CLKS ?
                                        CRD_RATIO_HOLD_CLKS : CRD_BREQ_HOLD_CLKS;

    crd_state_t state, next_state;
    logic [CRD_CNT_W-1:0] cnt, next_cnt;
    logic [CRD_CFG_W-1:0] cfg_drive, next_cfg_drive, captured, next_captured;
    logic rephase_en, next_rephase_en;
    logic hard, next_hard, bist, next_bist;
    logic soft_cnt_on, next_soft_cnt_on;
    logic [CRD_CNT_W-1:0] soft_cnt, next_soft_cnt;
    logic [CRD_BRIDGES-1:0] br_rst, next_br_rst;
    logic [CRD_CNT_W-1:0] br_cnt, next_br_cnt;
    logic [1:0] bank, next_bank;
    logic [3:0] ref_n, next_ref_n;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic wr_ctrl;
    logic in_reset, in_tail, cpu_rst;
    logic [1:0] hold_cnt, next_hold_cnt;

    function automatic logic [CRD_CNT_W-1:0] cnt_of(input int unsigned n);
        return CRD_CNT_W'(n);
    endfunction : cnt_of

    // writes land at the edge where the master samples ack, never earlier
    assign wr_ctrl = CYC_I && STB_I && WE_I && ack && ADR_I == ADR_CTRL && SEL_I[0];

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_hard = hard;
        next_bist = bist;
        next_captured = captured;
        next_bank = bank;
        next_ref_n = ref_n;
        next_cfg_drive = cfg_drive;
        next_rephase_en = rephase_en;
        next_soft_cnt_on = soft_cnt_on;
        next_soft_cnt = soft_cnt;
        next_br_rst = br_rst;
        next_br_cnt = br_cnt;
        next_ack = CYC_I && STB_I && !ack;
        next_rdata = 32'h0000_0000;
        if (CYC_I && STB_I && !ack && !WE_I) begin
            case (ADR_I)
                ADR_CTRL:   next_rdata = {28'h0000000, br_rst != '0, soft_cnt_on, bist, rephase_en};
                ADR_CFG:    next_rdata = {19'h00000, cfg_drive};
                ADR_STATUS: next_rdata = {29'h00000000, state == CRD_ST_REFRESH, state == CRD_ST_TAIL,
                                          state == CRD_ST_RESET};
                ADR_CAPT:   next_rdata = {19'h00000, captured};
                default:    next_rdata = 32'h0000_0000;
            endcase
        end
        // ratio hold trails every processor reset, soft ones too
        if (cpu_rst)
            next_hold_cnt = 2'(CRD_RATIO_HOLD_CLKS);
        else if (hold_cnt != 2'h0)
            next_hold_cnt = hold_cnt - 1'b1;
        else
            next_hold_cnt = hold_cnt;
        // counters end first so that a new command in the same cycle wins
        if (soft_cnt_on) begin
            next_soft_cnt = soft_cnt + 1'b1;
            if (soft_cnt == cnt_of(RESET_CLKS - 1))
                next_soft_cnt_on = 1'b0;
        end
        if (br_rst != '0) begin
            next_br_cnt = br_cnt + 1'b1;
            if (br_cnt == cnt_of(RESET_CLKS - 1))
                next_br_rst = '0;
        end
        if (CYC_I && STB_I && WE_I && ack && ADR_I == ADR_CFG && SEL_I[1:0] == 2'h3)
            next_cfg_drive = DAT_I[CRD_CFG_W-1:0];
        if (wr_ctrl) begin
            next_rephase_en = DAT_I[0];
            case (crd_cmd_t'(DAT_I[5:4]))
                CRD_HARD: if (state == CRD_ST_IDLE) begin
                    next_state = CRD_ST_RESET;
                    next_cnt = '0;
                    next_hard = 1'b1;
                    next_bist = DAT_I[1];
                end
                CRD_SOFT: begin
                    next_soft_cnt_on = 1'b1;
                    next_soft_cnt = '0;
                end
                CRD_BRIDGE: begin
                    next_br_rst[DAT_I[8]] = 1'b1;
                    next_br_cnt = '0;
                end
                default: ;
            endcase
        end
        case (state)
            CRD_ST_IDLE: ;
            CRD_ST_RESET: begin
                next_cnt = cnt + 1'b1;
                if (cnt == cnt_of(RESET_CLKS - 1)) begin
                    next_state = CRD_ST_TAIL;
                    next_cnt = '0;
                    next_captured = LINK.addr_i;
                    // power-good buffer goes back up with the processor reset
                    next_hard = 1'b0;
                    next_bist = 1'b0;
                end
            end
            CRD_ST_TAIL: begin
                next_cnt = cnt + 1'b1;
                if (cnt == cnt_of(TAIL_CLKS - 1)) begin
                    next_state = CRD_ST_REFRESH;
                    next_bank = '0;
                    next_ref_n = '0;
                end
            end
            CRD_ST_REFRESH: begin
                next_ref_n = ref_n + 1'b1;
                if (ref_n == 4'(CRD_REFRESH_PER_BANK - 1)) begin
                    next_ref_n = '0;
                    next_bank = bank + 1'b1;
                    if (bank == 2'(BANKS - 1))
                        next_state = CRD_ST_IDLE;
                end
            end
            default: next_state = CRD_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state       <= CRD_ST_RESET;
            cnt         <= '0;
            hard        <= 1'b0;
            bist        <= 1'b0;
            captured    <= '0;
            bank        <= '0;
            ref_n       <= '0;
            cfg_drive   <= CRD_CFG_RESET;
            rephase_en  <= CRD_REPHASE_RESET;
            soft_cnt_on <= 1'b0;
            soft_cnt    <= '0;
            br_rst      <= '0;
            br_cnt      <= '0;
            ack         <= 1'b0;
            hold_cnt    <= 2'(CRD_RATIO_HOLD_CLKS);
            rdata       <= '0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            hard        <= next_hard;
            bist        <= next_bist;
            captured    <= next_captured;
            bank        <= next_bank;
            ref_n       <= next_ref_n;
            cfg_drive   <= next_cfg_drive;
            rephase_en  <= next_rephase_en;
            soft_cnt_on <= next_soft_cnt_on;
            soft_cnt    <= next_soft_cnt;
            br_rst      <= next_br_rst;
            br_cnt      <= next_br_cnt;
            ack         <= next_ack;
            hold_cnt    <= next_hold_cnt;
            rdata       <= next_rdata;
        end
    end

    // processor reset spans RESET state; tail holds config, ratio and request lines
    assign in_reset = !RST_N || state == CRD_ST_RESET;
    assign in_tail  = state == CRD_ST_TAIL;
    assign cpu_rst  = in_reset || soft_cnt_on;

    assign DAT_O = rdata;
    assign ACK_O = ack;
    assign LINK.power_good_buffered_out = RST_N && !hard;
    assign LINK.cpu_reset_n = !cpu_rst;
    assign LINK.ratio_hold_reset_n = !(cpu_rst || hold_cnt != 2'h0);
    assign LINK.memory_subsystem_reset_n = !in_reset;
    assign LINK.bridge_reset_n = in_reset ? '0 : ~br_rst;
    // init is open drain: only driven low while hard reset asks for self-test
    assign LINK.cpu_init_o  = 1'b0;
    assign LINK.cpu_init_oe = RST_N && hard && bist && state == CRD_ST_RESET;
    assign LINK.addr_o  = cfg_drive;
    assign LINK.addr_oe = in_reset || (in_tail && cnt < cnt_of(CRD_CFG_TAIL_CLKS));
    assign LINK.bus_request_zero_o  = 1'b0;
    assign LINK.bus_request_zero_oe = in_reset ||
                                      (in_tail && cnt < cnt_of(CRD_BREQ_HOLD_CLKS));
    assign LINK.refresh_strobe = state == CRD_ST_REFRESH;
    assign LINK.refresh_bank   = bank;
    // re-phase spans any reset; clocks are undefined then unless disabled
    assign LINK.rephase = rephase_en && (in_reset || soft_cnt_on || br_rst != '0);
endmodule : crd_ctrl
`default_nettype wire

//--- core/crd_far.sv
// far end: processor, bridge and memory side reacting to reset distribution
`timescale 1ns/100ps
`default_nettype none
module crd_far
    import crd_pkg::*;
(
    input  wire logic                       CLK,             // host clock
    input  wire logic                       RST_N,           // synchronous reset
    input  wire logic [CRD_CFG_W-1:0]       EXT_CFG,         // external override of config lines
    input  wire logic                       EXT_CFG_EN,      // drive override onto config lines
    input  wire logic [1:0]                 RATIO_SEL,       // core-to-bus ratio selection
    input  wire logic                       SOFT_SRC_N,      // other soft reset sources, low active
    output logic      [1:0]                 RATIO_PINS,      // ratio driven to processor pins
    output logic      [CRD_CFG_W-1:0]       CPU_CFG,         // config captured by processor
    output logic                            CPU_INIT_N,      // combined init to processors
    output logic                            MEM_STATE_VALID, // memory holds transaction state
    output logic      [CRD_CNT_W-1:0]       REFRESH_COUNT,   // refreshes seen since memory reset
    crd_link_if.far                         LINK             // link to controller
);
    logic [CRD_CFG_W-1:0] cfg, next_cfg;
    logic prev_rst_n, next_prev_rst_n;
    logic mem_valid, next_mem_valid;
    logic [CRD_CNT_W-1:0] refs, next_refs;

    assign LINK.addr_i = EXT_CFG_EN ? EXT_CFG : (LINK.addr_oe ? LINK.addr_o : '0);

    always_comb begin
        next_prev_rst_n = LINK.cpu_reset_n;
        next_cfg = cfg;
        if (!prev_rst_n && LINK.cpu_reset_n)
            next_cfg = LINK.addr_i;
        next_mem_valid = LINK.memory_subsystem_reset_n;
        next_refs = refs;
        if (!LINK.memory_subsystem_reset_n)
            next_refs = '0;
        else if (LINK.refresh_strobe)
            next_refs = refs + 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg        <= '0;
            prev_rst_n <= 1'b0;
            mem_valid  <= 1'b0;
            refs       <= '0;
        end else begin
            cfg        <= next_cfg;
            prev_rst_n <= next_prev_rst_n;
            mem_valid  <= next_mem_valid;
            refs       <= next_refs;
        end
    end

    assign RATIO_PINS      = LINK.ratio_hold_reset_n ? 2'h0 : RATIO_SEL;
    assign CPU_CFG         = cfg;
    assign CPU_INIT_N      = !LINK.cpu_init_oe && SOFT_SRC_N;
    assign MEM_STATE_VALID = mem_valid;
    assign REFRESH_COUNT   = refs;
endmodule : crd_far
`default_nettype wire

//--- verification/crd_checker.sv
// assertions watching the reset distribution link between the two ends
`timescale 1ns/100ps
`default_nettype none
module crd_checker
    import crd_pkg::*;
(
    input wire logic                   CLK,                     // host clock
    input wire logic                   RST_N,                   // sync reset
    input wire logic                   power_good_buffered_out, // buffered power-good
    input wire logic                   cpu_reset_n,             // processor reset
    input wire logic                   ratio_hold_reset_n,      // ratio-hold reset
    input wire logic                   memory_subsystem_reset_n,// memory reset
    input wire logic [CRD_BRIDGES-1:0] bridge_reset_n,          // bridge resets
    input wire logic                   cpu_init_o,              // init level
    input wire logic                   cpu_init_oe,             // init enable
    input wire logic                   addr_oe,                 // config drive enable
    input wire logic                   bus_request_zero_o,      // bus request level
    input wire logic                   bus_request_zero_oe,     // bus request enable
    input wire logic                   refresh_strobe           // one refresh
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    pgood_hard_a:
        assert property (!power_good_buffered_out |-> !cpu_reset_n) else $error("pgood low outside reset");
    hard_state_a:
        assert property (!power_good_buffered_out |-> !memory_subsystem_reset_n && !ratio_hold_reset_n
            && bridge_reset_n == '0 && addr_oe && bus_request_zero_oe) else $error("hard reset output state");
    ratio_ext_a:
        assert property ($rose(cpu_reset_n) |-> !ratio_hold_reset_n ##1 !ratio_hold_reset_n ##1 ratio_hold_reset_n)
            else $error("ratio hold extension wrong");
    ratio_with_a:
        assert property (!cpu_reset_n |-> !ratio_hold_reset_n) else $error("ratio hold not with cpu reset");
    cfg_tail_a:
        assert property ($rose(cpu_reset_n) && addr_oe |-> ##1 !addr_oe) else $error("config drive tail wrong");
    breq_hold_a:
        assert property ($rose(cpu_reset_n) && bus_request_zero_oe |-> bus_request_zero_oe [*2] ##1 !bus_request_zero_oe)
            else $error("bus request hold wrong");
    breq_low_a:
        assert property (bus_request_zero_oe |-> !bus_request_zero_o) else $error("bus request driven high");
    init_hard_a:
        assert property (cpu_init_oe |-> !cpu_init_o && !power_good_buffered_out) else $error("init outside hard");
    soft_only_a:
        assert property ($fell(cpu_reset_n) && power_good_buffered_out |-> memory_subsystem_reset_n
            && bridge_reset_n == '1) else $error("soft reset spread");
    bridge_one_a:
        assert property (cpu_reset_n && $changed(bridge_reset_n) && bridge_reset_n != '1 |-> $onehot(~bridge_reset_n))
            else $error("more than one bridge reset");
    refresh_run_a:
        assert property (refresh_strobe |-> memory_subsystem_reset_n) else $error("refresh under memory reset");
endmodule : crd_checker
`default_nettype wire

//--- verification/chipset_reset_distribution_tb.sv
// self-checking bench joining controller and far end
`timescale 1ns/100ps
`default_nettype none
module chipset_reset_distribution_tb;
    import crd_pkg::*;
    logic        CLK = 1'b0, RST_N = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0, ACK_O;
    logic [3:0]  ADR_I = 4'h0, SEL_I = 4'h0;
    logic [31:0] DAT_I = 32'h0, DAT_O, lfsr_q = 32'h1C7183BD, cfg_val, ext_val, rdv;
    logic [12:0] EXT_CFG = 13'h0000, CPU_CFG;
    logic        EXT_CFG_EN = 1'b0, SOFT_SRC_N = 1'b1, CPU_INIT_N, MEM_STATE_VALID, clr = 1'b0;
    logic [1:0]  RATIO_SEL = 2'h0, RATIO_PINS, seen_br = 2'h0;
    logic [7:0]  REFRESH_COUNT;
    logic        seen_init = 1'b0, seen_pg_low = 1'b0, seen_rephase = 1'b0, seen_mem_lost = 1'b0;
    logic [31:0] notes[$];
    int          miscompares = 0, total_checks = 0;
    logic [31:0] cmds[4] = '{32'h20, 32'h21, 32'h31, 32'h131};
    always #2 CLK = ~CLK;
    crd_link_if u_crd_link_if ();
    crd_ctrl #(.RESET_CLKS(4)) u_crd_ctrl (.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LINK(u_crd_link_if.ctrl));
    crd_far u_crd_far (.CLK(CLK), .RST_N(RST_N), .EXT_CFG(EXT_CFG), .EXT_CFG_EN(EXT_CFG_EN), .RATIO_SEL(RATIO_SEL),
        .SOFT_SRC_N(SOFT_SRC_N), .RATIO_PINS(RATIO_PINS), .CPU_CFG(CPU_CFG), .CPU_INIT_N(CPU_INIT_N),
        .MEM_STATE_VALID(MEM_STATE_VALID), .REFRESH_COUNT(REFRESH_COUNT), .LINK(u_crd_link_if.far));
    crd_checker u_crd_checker (.CLK(CLK), .RST_N(RST_N),
        .power_good_buffered_out(u_crd_link_if.power_good_buffered_out), .cpu_reset_n(u_crd_link_if.cpu_reset_n),
        .ratio_hold_reset_n(u_crd_link_if.ratio_hold_reset_n), .bridge_reset_n(u_crd_link_if.bridge_reset_n),
        .memory_subsystem_reset_n(u_crd_link_if.memory_subsystem_reset_n), .cpu_init_o(u_crd_link_if.cpu_init_o),
        .cpu_init_oe(u_crd_link_if.cpu_init_oe), .addr_oe(u_crd_link_if.addr_oe),
        .bus_request_zero_o(u_crd_link_if.bus_request_zero_o), .bus_request_zero_oe(u_crd_link_if.bus_request_zero_oe),
        .refresh_strobe(u_crd_link_if.refresh_strobe));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // single classic cycle; waits for ack, then idles one cycle
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= we;
        ADR_I <= adr;
        SEL_I <= 4'hF;
        DAT_I <= dat;
        do begin
            @(posedge CLK);
        end while (ACK_O !== 1'b1);
        rdv = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I  <= 1'b0;
        @(posedge CLK);
    endtask : wb

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
        notes.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask : rd_chk

    // polls without a note, so the monitor leaves these reads alone
    task automatic poll(input logic [3:0] adr, input logic [31:0] mask);
        int n;
        n = 0;
        do begin
            wb(1'b0, adr, 32'h0);
            n++;
        end while ((rdv & mask) !== 32'h0 && n < 200);
        if (n >= 200) miscompares++;
    endtask : poll

    task automatic start(input logic [31:0] cmd);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
        wb(1'b1, 4'h0, cmd);
    endtask : start

    always @(posedge CLK) begin
        if (ACK_O && !WE_I && notes.size() > 0) check(DAT_O, notes.pop_front());
        if (RST_N) begin
            if (!u_crd_link_if.ratio_hold_reset_n) check(32'(RATIO_PINS), 32'(RATIO_SEL));
            check(32'(CPU_INIT_N), 32'(SOFT_SRC_N & ~(u_crd_link_if.cpu_init_oe & ~u_crd_link_if.cpu_init_o)));
        end
        seen_init    <= !clr && (seen_init || u_crd_link_if.cpu_init_oe);
        seen_pg_low  <= !clr && (seen_pg_low || (RST_N && !u_crd_link_if.power_good_buffered_out));
        seen_rephase <= !clr && (seen_rephase || u_crd_link_if.rephase);
        seen_mem_lost <= !clr && (seen_mem_lost || (RST_N && !MEM_STATE_VALID));
        seen_br      <= clr ? 2'h0 : seen_br | ~u_crd_link_if.bridge_reset_n;
    end

    initial begin
        #40000;
        miscompares++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge CLK);
        check(32'({u_crd_link_if.power_good_buffered_out, u_crd_link_if.cpu_reset_n, u_crd_link_if.ratio_hold_reset_n,
            u_crd_link_if.memory_subsystem_reset_n, u_crd_link_if.bridge_reset_n, u_crd_link_if.addr_oe,
            u_crd_link_if.bus_request_zero_oe}), 32'h3);
        RST_N <= 1'b1;
        @(posedge CLK);
        poll(4'h8, 32'h7);
        check(32'(REFRESH_COUNT), CRD_REFRESH_PER_BANK * CRD_BANKS);
        check(32'(MEM_STATE_VALID), 32'h1);
        rd_chk(4'h0, 32'h1);
        rd_chk(4'h4, 32'(CRD_CFG_RESET));
        $display("test power-good reset done");
        for (int i = 0; i < 2; i++) begin
            lfsr_q = lfsr(lfsr_q);
            cfg_val = {19'h0, lfsr_q[12:0]};
            ext_val = {19'h0, lfsr_q[25:13]};
            EXT_CFG <= ext_val[12:0];
            EXT_CFG_EN <= i[0];
            RATIO_SEL <= lfsr_q[27:26];
            SOFT_SRC_N <= lfsr_q[28];
            wb(1'b1, 4'h4, cfg_val);
            start(i == 0 ? 32'h13 : 32'h11);
            poll(4'h8, 32'h7);
            check(32'(seen_init), 32'(i == 0));
            check(32'({seen_pg_low, seen_rephase}), 32'h3);
            check(32'({seen_mem_lost, MEM_STATE_VALID}), 32'h3);
            check(32'(REFRESH_COUNT), CRD_REFRESH_PER_BANK * CRD_BANKS);
            rd_chk(4'h4, cfg_val);
            rd_chk(4'hC, i ? ext_val : cfg_val);
            check(32'(CPU_CFG), i ? ext_val : cfg_val);
            $display("test hard reset %0d done", i);
        end
        for (int k = 0; k < 4; k++) begin
            lfsr_q = lfsr(lfsr_q);
            SOFT_SRC_N <= lfsr_q[0];
            start(cmds[k]);
            poll(4'h0, 32'hC);
            check(32'(seen_rephase), 32'(k != 0));
            check(32'({seen_pg_low, seen_init}), 32'h0);
            check(32'(seen_mem_lost), 32'h0);
            check(32'(seen_br), k < 2 ? 32'h0 : 32'(k - 1));
            check(32'(REFRESH_COUNT), CRD_REFRESH_PER_BANK * CRD_BANKS);
            $display("test command %0d done", k);
        end
        summarize();
    end
endmodule : chipset_reset_distribution_tb
`default_nettype wire
